// [logic/vtc_pkg.sv]
package vtc_pkg;
  // Command wrapper layout, byte offsets within the 31-byte wrapper.
  localparam int          CBW_BYTES      = 31;
  localparam int          LEN_OFS        = 8;
  localparam int          FLAG_OFS       = 12;
  localparam int          CBLEN_OFS      = 14;
  localparam int          CB_OFS         = 15;
  localparam int          DIR_BIT        = 7;
  localparam logic [31:0] CBW_SIGNATURE  = 32'h43425355;
  localparam logic [7:0]  CB_LENGTH      = 8'h10;
  // Vendor command block contents.
  localparam logic [7:0]  CFG_DESIG_ADDR = 8'h04;
  localparam logic [7:0]  DESIG_DEFAULT  = 8'h24;
  localparam logic [7:0]  SUB_CONFIG     = 8'h26;
  localparam logic [7:0]  SUB_PIN_TEST   = 8'h27;
  localparam logic [7:0]  SRC_EEPROM     = 8'h02;
  localparam logic [31:0] CFG_MAX_LEN    = 32'h0000_00FF;
  localparam logic [31:0] TEST_BYTES     = 32'h0000_0004;
  // Pin test data byte 1 fields.
  localparam int          TB1_DD_DRIVE   = 7;
  localparam int          TB1_MODE_SEL   = 6;
  // Status byte that closes every command.
  localparam logic [7:0]  ST_PASS        = 8'h00;
  localparam logic [7:0]  ST_FAIL        = 8'h01;
  // Host controller registers on APB.
  localparam logic [7:0]  A_CTRL         = 8'h00;
  localparam logic [7:0]  A_LEN          = 8'h04;
  localparam logic [7:0]  A_TXWORD       = 8'h08;
  localparam logic [7:0]  A_RXWORD       = 8'h0C;
  localparam logic [7:0]  A_STATUS       = 8'h10;
  localparam int          CTRL_GO        = 0;
  localparam int          CTRL_DIR_IN    = 1;
  localparam int          CTRL_TEST      = 2;
  localparam int          ST_DONE        = 0;
  localparam int          ST_PASSED      = 1;
  localparam int          ST_REFUSED     = 2;

  typedef enum logic [4:0] {
    VTC_D_CBW  = 5'b00001,
    VTC_D_DEC  = 5'b00010,
    VTC_D_DOUT = 5'b00100,
    VTC_D_DIN  = 5'b01000,
    VTC_D_STAT = 5'b10000
  } vtc_dev_state_t;

  typedef enum logic [4:0] {
    VTC_H_IDLE = 5'b00001,
    VTC_H_CBW  = 5'b00010,
    VTC_H_DOUT = 5'b00100,
    VTC_H_DIN  = 5'b01000,
    VTC_H_STAT = 5'b10000
  } vtc_host_state_t;
endpackage

// [logic/vtc_link_if.sv]
`timescale 1ns/1ps
interface vtc_link_if;
  logic       h2d_valid;
  logic [7:0] h2d_data;
  logic       h2d_ready;
  logic       d2h_valid;
  logic [7:0] d2h_data;
  logic       d2h_ready;
  modport dev (input h2d_valid, h2d_data, d2h_ready,
               output h2d_ready, d2h_valid, d2h_data);
  modport hst (output h2d_valid, h2d_data, d2h_ready,
               input h2d_ready, d2h_valid, d2h_data);
endinterface

// [logic/vtc_device.sv]
// What this block does
// - Byte 0 must match configured vendor designator.
// - Subcommand 0x26 selects EEPROM load or read.
// - Config byte 2 zero, byte 3 0x02; only byte 3 is checked.
// - Config start address is 0x0000.
// - Config bytes 6 to 15 are zero; not checked.
// - EEPROM transfer never exceeds 255 bytes.
// - Data length from wrapper bytes 8-11.
// - Direction from wrapper byte 12 bit 7.
// - Subcommand 0x27 marks a pin test command.
// - Test block bytes 2 to 15 are zero; not checked.
// - Test load enters manufacturing test mode.
// - Test mode: pins follow loaded test data.
// - Test load applies only bytes 0 to 3.
// - Only hard reset leaves test mode.
// - Test read returns a pin snapshot.
// - Test read: only bytes 0-3 meaningful.
// - Byte 1 bit 7 drives or floats data.
// - Byte 1 bit 6 reads mode select.
// - EEPROM sits at I2C address 2 or 4.
// - Reset line low at power-up: board test.
// - Bad EEPROM signature: board test mode.
// - Designator comes from config byte 0x04; not read, taken from the vendor_command_designator input.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module vtc_device
  import vtc_pkg::*;
#(
  parameter logic [2:0] EEPROM_PHYS_ADDR = 3'h2
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // Link to the host
  vtc_link_if.dev          link,
  // Boot configuration
  input  wire logic [7:0]  vendor_command_designator,
  input  wire logic        eeprom_signature_bad,
  // EEPROM byte port
  output logic      [2:0]  eep_dev_addr,
  output logic      [7:0]  eep_addr,
  output logic      [7:0]  eep_wdata,
  output logic             eep_wr,
  output logic             eep_rd,
  input  wire logic [7:0]  eep_rdata,
  // Normal bridge drive, in pin test byte layout
  input  wire logic [7:0]  norm_b0,
  input  wire logic [7:0]  norm_b1,
  input  wire logic [15:0] norm_dd,
  input  wire logic        norm_dd_oe,
  // ATA pin drive
  output logic             ata_device_reset_n_out,
  output logic      [1:0]  cs_n_out,
  output logic             drive_power_valid_out,
  output logic      [1:0]  da_out,
  output logic             dmack_n_out,
  output logic             dior_n_out,
  output logic             diow_n_out,
  output logic      [15:0] dd_out,
  output logic             dd_oe,
  // ATA pin sense
  input  wire logic        ata_device_reset_n_in,
  input  wire logic        da2_in,
  input  wire logic [1:0]  cs_n_in,
  input  wire logic        drive_power_valid_in,
  input  wire logic [1:0]  da_in,
  input  wire logic        intrq_in,
  input  wire logic        ata_bus_power_enable_in,
  input  wire logic        dmarq_in,
  input  wire logic        iordy_in,
  input  wire logic        dmack_n_in,
  input  wire logic        dior_n_in,
  input  wire logic        diow_n_in,
  input  wire logic [15:0] dd_in,
  // Mode status
  output logic             board_test_mode,
  output logic             pin_test_mode
);
  generate
    if (EEPROM_PHYS_ADDR != 3'h2 && EEPROM_PHYS_ADDR != 3'h4) begin : g_chk
      $error("EEPROM_PHYS_ADDR must be 2 or 4");
    end
  endgenerate

  vtc_dev_state_t state_reg;
  vtc_dev_state_t state_next;
  logic [7:0]     cbw_reg [CBW_BYTES];
  logic [4:0]     idx_reg;
  logic [31:0]    cnt_reg;
  logic [31:0]    len;
  logic           dir_in;
  logic           boot_done_reg;
  logic           ok_reg;
  logic           is_cfg_reg;
  logic           rd_wait_reg;
  logic [7:0]     tst_reg  [4];
  logic [7:0]     snap_reg [4];
  logic           h2d_ready_reg;
  logic           d2h_valid_reg;
  logic [7:0]     d2h_data_reg;
  logic           h2d_take;
  logic           d2h_take;
  logic           last;

  assign link.h2d_ready = h2d_ready_reg;
  assign link.d2h_valid = d2h_valid_reg;
  assign link.d2h_data  = d2h_data_reg;
  assign h2d_take = link.h2d_valid && h2d_ready_reg;
  assign d2h_take = d2h_valid_reg && link.d2h_ready;
  assign len    = {cbw_reg[LEN_OFS+3], cbw_reg[LEN_OFS+2],
                   cbw_reg[LEN_OFS+1], cbw_reg[LEN_OFS]};
  assign dir_in = cbw_reg[FLAG_OFS][DIR_BIT];
  assign last   = (cnt_reg == len - 32'h0000_0001);
  assign eep_dev_addr = EEPROM_PHYS_ADDR;

  // The strap is caught one edge after reset release, never by the reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_done_reg   <= 1'b0;
      board_test_mode <= 1'b0;
    end else if (ce && !boot_done_reg) begin
      boot_done_reg   <= 1'b1;
      board_test_mode <= !ata_device_reset_n_in
                         || eeprom_signature_bad;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      VTC_D_CBW:
        if (h2d_take && idx_reg == 5'(CBW_BYTES - 1)) begin
          state_next = VTC_D_DEC;
        end
      VTC_D_DEC:
        if (len == 32'h0) begin
          state_next = VTC_D_STAT;
        end else if (dir_in) begin
          state_next = VTC_D_DIN;
        end else begin
          state_next = VTC_D_DOUT;
        end
      VTC_D_DOUT:
        if (h2d_take && last) begin
          state_next = VTC_D_STAT;
        end
      VTC_D_DIN:
        if (d2h_take && last) begin
          state_next = VTC_D_STAT;
        end
      VTC_D_STAT:
        if (d2h_take) begin
          state_next = VTC_D_CBW;
        end
      default:
        state_next = VTC_D_CBW;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= VTC_D_CBW;
      h2d_ready_reg <= 1'b0;
    end else if (ce) begin
      state_reg     <= state_next;
      h2d_ready_reg <= boot_done_reg && (state_next == VTC_D_CBW
                                         || state_next == VTC_D_DOUT);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_reg <= 5'h0;
      for (int i = 0; i < CBW_BYTES; i++) begin
        cbw_reg[i] <= 8'h00;
      end
    end else if (ce && state_reg == VTC_D_CBW && h2d_take) begin
      cbw_reg[idx_reg] <= link.h2d_data;
      idx_reg <= (idx_reg == 5'(CBW_BYTES - 1)) ? 5'h0 : idx_reg + 5'h1;
    end
  end

  // Decode. Reserved bytes other than the source selector are not checked.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ok_reg        <= 1'b0;
      is_cfg_reg    <= 1'b0;
      pin_test_mode <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        snap_reg[i] <= 8'h00;
      end
    end else if (ce && state_reg == VTC_D_DEC) begin
      is_cfg_reg <= (cbw_reg[CB_OFS+1] == SUB_CONFIG);
      ok_reg <= board_test_mode
                && cbw_reg[CB_OFS] == vendor_command_designator
                && ((cbw_reg[CB_OFS+1] == SUB_CONFIG
                     && cbw_reg[CB_OFS+3] == SRC_EEPROM
                     && len <= CFG_MAX_LEN)
                    || cbw_reg[CB_OFS+1] == SUB_PIN_TEST);
      if (board_test_mode && cbw_reg[CB_OFS] == vendor_command_designator
          && cbw_reg[CB_OFS+1] == SUB_PIN_TEST) begin
        if (!dir_in) begin
          pin_test_mode <= 1'b1;
        end else begin
          snap_reg[0] <= {ata_device_reset_n_in, da2_in, cs_n_in,
                          drive_power_valid_in, da_in, intrq_in};
          snap_reg[1] <= {1'b0, board_test_mode,
                          ata_bus_power_enable_in, dmarq_in, iordy_in,
                          dmack_n_in, dior_n_in, diow_n_in};
          snap_reg[2] <= dd_in[7:0];
          snap_reg[3] <= dd_in[15:8];
        end
      end
    end
  end

  // Data phase counter and payload handling.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg     <= 32'h0;
      rd_wait_reg <= 1'b0;
      eep_wr      <= 1'b0;
      eep_rd      <= 1'b0;
      eep_addr    <= 8'h00;
      eep_wdata   <= 8'h00;
      d2h_valid_reg <= 1'b0;
      d2h_data_reg  <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        tst_reg[i] <= 8'h00;
      end
    end else if (ce) begin
      eep_wr <= 1'b0;
      eep_rd <= 1'b0;
      if (state_reg == VTC_D_DEC) begin
        cnt_reg <= 32'h0;
      end
      if (state_reg == VTC_D_DOUT && h2d_take) begin
        cnt_reg <= cnt_reg + 32'h1;
        if (ok_reg && is_cfg_reg) begin
          eep_wr    <= 1'b1;
          eep_addr  <= cnt_reg[7:0];
          eep_wdata <= link.h2d_data;
        end else if (ok_reg && cnt_reg < TEST_BYTES) begin
          tst_reg[cnt_reg[1:0]] <= link.h2d_data;
        end
      end
      if (state_reg == VTC_D_DIN) begin
        if (d2h_take) begin
          d2h_valid_reg <= 1'b0;
          cnt_reg <= cnt_reg + 32'h1;
        end else if (!d2h_valid_reg && !rd_wait_reg) begin
          rd_wait_reg <= 1'b1;
          eep_rd      <= ok_reg && is_cfg_reg;
          eep_addr    <= cnt_reg[7:0];
        end else if (rd_wait_reg) begin
          rd_wait_reg   <= 1'b0;
          d2h_valid_reg <= 1'b1;
          if (!ok_reg) begin
            d2h_data_reg <= 8'h00;
          end else if (is_cfg_reg) begin
            d2h_data_reg <= eep_rdata;
          end else if (cnt_reg < TEST_BYTES) begin
            d2h_data_reg <= snap_reg[cnt_reg[1:0]];
          end else begin
            d2h_data_reg <= 8'h00;
          end
        end
      end
      if (state_reg == VTC_D_STAT) begin
        if (d2h_take) begin
          d2h_valid_reg <= 1'b0;
        end else begin
          d2h_valid_reg <= 1'b1;
          d2h_data_reg  <= ok_reg ? ST_PASS : ST_FAIL;
        end
      end
    end
  end

  // Pin drive: loaded test data replaces normal drive in test mode.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ata_device_reset_n_out <= 1'b1;
      cs_n_out               <= 2'h3;
      drive_power_valid_out  <= 1'b0;
      da_out                 <= 2'h0;
      dmack_n_out            <= 1'b1;
      dior_n_out             <= 1'b1;
      diow_n_out             <= 1'b1;
      dd_out                 <= 16'h0000;
      dd_oe                  <= 1'b0;
    end else if (ce) begin
      if (pin_test_mode) begin
        ata_device_reset_n_out <= tst_reg[0][7];
        cs_n_out               <= tst_reg[0][5:4];
        drive_power_valid_out  <= tst_reg[0][3];
        da_out                 <= tst_reg[0][2:1];
        dmack_n_out            <= tst_reg[1][2];
        dior_n_out             <= tst_reg[1][1];
        diow_n_out             <= tst_reg[1][0];
        dd_out                 <= {tst_reg[3], tst_reg[2]};
        dd_oe                  <= tst_reg[1][TB1_DD_DRIVE];
      end else begin
        ata_device_reset_n_out <= norm_b0[7];
        cs_n_out               <= norm_b0[5:4];
        drive_power_valid_out  <= norm_b0[3];
        da_out                 <= norm_b0[2:1];
        dmack_n_out            <= norm_b1[2];
        dior_n_out             <= norm_b1[1];
        diow_n_out             <= norm_b1[0];
        dd_out                 <= norm_dd;
        dd_oe                  <= norm_dd_oe;
      end
    end
  end
endmodule

// [logic/vtc_host.sv]
`timescale 1ns/1ps
module vtc_host
  import vtc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link to the device
  vtc_link_if.hst          link
);
  vtc_host_state_t state_reg;
  logic [31:0]     len_reg;
  logic [31:0]     tx_reg;
  logic [31:0]     rx_reg;
  logic [7:0]      desig_reg;
  logic            dir_in_reg;
  logic            test_reg;
  logic            done_reg;
  logic            pass_reg;
  logic            refused_reg;
  logic [31:0]     cnt_reg;
  logic            h2d_valid_reg;
  logic [7:0]      h2d_data_reg;
  logic            d2h_ready_reg;
  logic            wr_acc;
  logic            go;
  logic            refuse;
  logic            h2d_take;
  logic            d2h_take;
  logic            last;

  // Build one wrapper byte; unlisted bytes stay zero.
  function automatic logic [7:0] cbw_byte(input logic [4:0] i);
    logic [7:0] b;
    b = 8'h00;
    if (i < 5'd4) begin
      b = CBW_SIGNATURE[8*i +: 8];
    end else if (i >= 5'(LEN_OFS) && i < 5'(LEN_OFS + 4)) begin
      b = len_reg[8*(i - 5'(LEN_OFS)) +: 8];
    end else if (i == 5'(FLAG_OFS)) begin
      b = {dir_in_reg, 7'h00};
    end else if (i == 5'(CBLEN_OFS)) begin
      b = CB_LENGTH;
    end else if (i == 5'(CB_OFS)) begin
      b = desig_reg;
    end else if (i == 5'(CB_OFS + 1)) begin
      b = test_reg ? SUB_PIN_TEST : SUB_CONFIG;
    end else if (i == 5'(CB_OFS + 3) && !test_reg) begin
      b = SRC_EEPROM;
    end
    return b;
  endfunction

  assign link.h2d_valid = h2d_valid_reg;
  assign link.h2d_data  = h2d_data_reg;
  assign link.d2h_ready = d2h_ready_reg;
  assign h2d_take = h2d_valid_reg && link.h2d_ready;
  assign d2h_take = link.d2h_valid && d2h_ready_reg;
  assign last     = (cnt_reg == len_reg - 32'h0000_0001);
  assign wr_acc   = psel && penable && pready && pwrite;
  assign go       = wr_acc && paddr == A_CTRL && pwdata[CTRL_GO]
                    && state_reg == VTC_H_IDLE;
  assign refuse   = go && !pwdata[CTRL_TEST]
                    && len_reg > CFG_MAX_LEN;

  // APB answers one cycle after setup; unmapped addresses raise pslverr.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable) begin
        if (paddr == A_CTRL) begin
          prdata <= {16'h0, desig_reg, 5'h0, test_reg, dir_in_reg,
                     state_reg != VTC_H_IDLE};
        end else if (paddr == A_LEN) begin
          prdata <= len_reg;
        end else if (paddr == A_TXWORD) begin
          prdata <= tx_reg;
        end else if (paddr == A_RXWORD) begin
          prdata <= rx_reg;
        end else if (paddr == A_STATUS) begin
          prdata <= {29'h0, refused_reg, pass_reg, done_reg};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Command settings; frozen while a command runs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      len_reg    <= 32'h0;
      tx_reg     <= 32'h0;
      desig_reg  <= DESIG_DEFAULT;
      dir_in_reg <= 1'b0;
      test_reg   <= 1'b0;
    end else if (ce && wr_acc && state_reg == VTC_H_IDLE) begin
      if (paddr == A_CTRL) begin
        desig_reg  <= pwdata[15:8];
        dir_in_reg <= pwdata[CTRL_DIR_IN];
        test_reg   <= pwdata[CTRL_TEST];
      end else if (paddr == A_LEN) begin
        len_reg <= pwdata;
      end else if (paddr == A_TXWORD) begin
        tx_reg <= pwdata;
      end
    end
  end

  // Done and refused flags clear by writing one; a new event wins over the clear.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg    <= 1'b0;
      pass_reg    <= 1'b0;
      refused_reg <= 1'b0;
    end else if (ce) begin
      if (state_reg == VTC_H_STAT && d2h_take) begin
        done_reg <= 1'b1;
        pass_reg <= (link.d2h_data == ST_PASS);
      end else if (wr_acc && paddr == A_STATUS && pwdata[ST_DONE]) begin
        done_reg <= 1'b0;
      end
      if (refuse) begin
        refused_reg <= 1'b1;
      end else if (wr_acc && paddr == A_STATUS && pwdata[ST_REFUSED]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= VTC_H_IDLE;
      cnt_reg       <= 32'h0;
      rx_reg        <= 32'h0;
      h2d_valid_reg <= 1'b0;
      h2d_data_reg  <= 8'h00;
      d2h_ready_reg <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        VTC_H_IDLE:
          if (go && !refuse) begin
            state_reg     <= VTC_H_CBW;
            cnt_reg       <= 32'h0;
            h2d_valid_reg <= 1'b1;
            h2d_data_reg  <= CBW_SIGNATURE[7:0];
          end
        VTC_H_CBW:
          if (h2d_take) begin
            cnt_reg      <= cnt_reg + 32'h1;
            h2d_data_reg <= cbw_byte(5'(cnt_reg + 32'h1));
            if (cnt_reg == 32'(CBW_BYTES - 1)) begin
              cnt_reg <= 32'h0;
              if (len_reg == 32'h0) begin
                state_reg     <= VTC_H_STAT;
                h2d_valid_reg <= 1'b0;
                d2h_ready_reg <= 1'b1;
              end else if (dir_in_reg) begin
                state_reg     <= VTC_H_DIN;
                h2d_valid_reg <= 1'b0;
                d2h_ready_reg <= 1'b1;
              end else begin
                state_reg    <= VTC_H_DOUT;
                h2d_data_reg <= tx_reg[7:0];
              end
            end
          end
        VTC_H_DOUT:
          if (h2d_take) begin
            cnt_reg      <= cnt_reg + 32'h1;
            h2d_data_reg <= tx_reg[8*2'(cnt_reg + 32'h1) +: 8];
            if (last) begin
              state_reg     <= VTC_H_STAT;
              h2d_valid_reg <= 1'b0;
              d2h_ready_reg <= 1'b1;
            end
          end
        VTC_H_DIN:
          if (d2h_take) begin
            cnt_reg <= cnt_reg + 32'h1;
            if (cnt_reg < TEST_BYTES) begin
              rx_reg[8*cnt_reg[1:0] +: 8] <= link.d2h_data;
            end
            if (last) begin
              state_reg <= VTC_H_STAT;
            end
          end
        VTC_H_STAT:
          if (d2h_take) begin
            state_reg     <= VTC_H_IDLE;
            d2h_ready_reg <= 1'b0;
          end
        default:
          state_reg <= VTC_H_IDLE;
      endcase
    end
  end
endmodule

// [tb/vtc_link_properties.sv]
`timescale 1ns/1ps
// Watches the byte link where both ends are design code.
module vtc_link_properties (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       h2d_valid,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_ready,
  input wire logic       d2h_valid,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_h2d_keep_valid: assert property (
    h2d_valid && !h2d_ready |=> h2d_valid) else $error("host byte dropped");
  a_h2d_keep_data: assert property (
    h2d_valid && !h2d_ready |=> $stable(h2d_data)) else $error("h2d moved");
  a_d2h_keep_valid: assert property (
    d2h_valid && !d2h_ready |=> d2h_valid) else $error("dev byte dropped");
  a_d2h_keep_data: assert property (
    d2h_valid && !d2h_ready |=> $stable(d2h_data)) else $error("d2h moved");
  a_h2d_taken_soon: assert property (
    h2d_valid |-> ##[0:100] h2d_ready) else $error("device never took");
  a_d2h_taken_soon: assert property (
    d2h_valid |-> ##[0:100] d2h_ready) else $error("host never took");
  a_rst_ready_low: assert property (
    $rose(arst_n) |-> !h2d_ready && !d2h_valid) else $error("early link");
  a_rst_ready_up: assert property (
    $rose(arst_n) |-> ##[1:4] h2d_ready) else $error("device not ready");
  a_rst_host_quiet: assert property (
    $rose(arst_n) |-> !h2d_valid && !d2h_ready) else $error("early host");
  c_h2d_move: cover property (h2d_valid && h2d_ready);
  c_d2h_move: cover property (d2h_valid && d2h_ready);
  c_d2h_stall: cover property (d2h_valid && !d2h_ready);
endmodule

// [tb/vendor_test_command_decoder_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
  end end
module vendor_test_command_decoder_tb import vtc_pkg::*;;
  logic clk = 0, arst_n = 0, ce = 1, eeprom_signature_bad = 1;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic norm_dd_oe = 1, eep_wr, eep_rd, dd_oe, board_test_mode;
  logic pin_test_mode, ata_device_reset_n_out, drive_power_valid_out;
  logic dmack_n_out, dior_n_out, diow_n_out, da2_in, intrq_in;
  logic ata_device_reset_n_in, drive_power_valid_in, iordy_in;
  logic ata_bus_power_enable_in, dmarq_in, dmack_n_in, dior_n_in;
  logic diow_n_in;
  logic [1:0] cs_n_out, da_out, cs_n_in, da_in;
  logic [2:0] eep_dev_addr;
  logic [7:0] paddr = 0, vendor_command_designator, eep_rdata, eep_addr;
  logic [7:0] eep_wdata, norm_b0, norm_b1, d, mem [256];
  logic [15:0] norm_dd, dd_out, dd_in;
  logic [31:0] pwdata = 0, prdata, pv, w, st, r;
  int n_errors = 0, total_checks = 0;
  assign {ata_device_reset_n_in, da2_in, cs_n_in, drive_power_valid_in,
          da_in, intrq_in} = pv[7:0];
  assign {ata_bus_power_enable_in, dmarq_in, iordy_in, dmack_n_in,
          dior_n_in, diow_n_in} = pv[13:8];
  assign dd_in = pv[31:16];
  vtc_link_if lnk ();
  vtc_device vtc_device_inst (.link(lnk), .*);
  vtc_host vtc_host_inst (.link(lnk), .*);
  vtc_link_properties vtc_link_properties_inst (.clk(clk), .arst_n(arst_n),
    .h2d_valid(lnk.h2d_valid), .h2d_data(lnk.h2d_data),
    .h2d_ready(lnk.h2d_ready), .d2h_valid(lnk.d2h_valid),
    .d2h_data(lnk.d2h_data), .d2h_ready(lnk.d2h_ready));
  initial forever #2.5 clk = ~clk;
  // Byte stand-in for the EEPROM; the device samples read data at the
  // edge that closes its read pulse, so the data follows the address.
  assign eep_rdata = mem[eep_addr];
  always @(posedge clk) begin
    if (eep_wr) mem[eep_addr] <= eep_wdata;
  end
  function automatic logic [31:0] snap_exp(input logic [31:0] p);
    return {p[31:16], 2'b01, p[13:0]};
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] dat);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // Polls status; a refused command never reports done, so both end it.
  task automatic cmd(input logic [7:0] ds, input logic [1:0] m,
                     input logic [31:0] len, tx);
    apb(1, A_LEN, len);
    apb(1, A_TXWORD, tx);
    apb(1, A_CTRL, {16'h0, ds, 5'h0, m, 1'b1});
    do begin
      apb(0, A_STATUS, 0);
    end while ((r[ST_DONE] | r[ST_REFUSED]) !== 1'b1);
    st = r;
    apb(1, A_STATUS, 32'h5);
  endtask
  // One-cycle reset pulse with chosen boot straps.
  task automatic rst(input logic bad, input logic pin);
    eeprom_signature_bad <= bad;
    pv[7] <= pin;
    arst_n <= 0;
    @(posedge clk);
    arst_n <= 1;
    repeat (3) @(posedge clk);
  endtask
  task summarize;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  initial begin
    void'($urandom(89819));
    pv <= $urandom;
    w = $urandom;
    d = 8'($urandom);
    vendor_command_designator <= d;
    {norm_b0, norm_b1, norm_dd} <= $urandom;
    repeat (4) @(posedge clk);
    arst_n <= 1;
    repeat (3) @(posedge clk);
    `CHK(board_test_mode, 1'b1)
    `CHK(dd_out, norm_dd)
    `CHK(eep_dev_addr, 3'h2)
    apb(0, 8'h40, 0);
    `CHK(err, 1'b1)
    cmd(d, 2'b00, 255, w);
    `CHK(st[ST_PASSED], 1'b1)
    `CHK(mem[254], w[23:16])
    `CHK(mem[4], w[7:0])
    cmd(d, 2'b00, 4, ~w);
    `CHK({mem[3], mem[2], mem[1], mem[0]}, ~w)
    cmd(d, 2'b01, 4, 0);
    apb(0, A_RXWORD, 0);
    `CHK(r, ~w)
    cmd(d, 2'b00, 256, w);
    `CHK(st[ST_REFUSED], 1'b1)
    cmd(~d, 2'b10, 4, w);
    `CHK(st[ST_PASSED], 1'b0)
    `CHK(pin_test_mode, 1'b0)
    for (int i = 0; i < 2; i++) begin
      w[15] = i[0];
      cmd(d, 2'b10, 4, w);
      `CHK(pin_test_mode, 1'b1)
      `CHK(dd_oe, w[15])
      `CHK(dd_out, w[31:16])
      `CHK({cs_n_out, da_out, diow_n_out}, {w[5:4], w[2:1], w[8]})
      `CHK(ata_device_reset_n_out, w[7])
      `CHK(drive_power_valid_out, w[3])
      `CHK({dmack_n_out, dior_n_out}, w[10:9])
    end
    cmd(d, 2'b11, 4, 0);
    apb(0, A_RXWORD, 0);
    `CHK(r, snap_exp(pv))
    cmd(d, 2'b01, 4, 0);
    `CHK(pin_test_mode, 1'b1)
    rst(1'b0, 1'b0);
    `CHK(pin_test_mode, 1'b0)
    `CHK(board_test_mode, 1'b1)
    rst(1'b0, 1'b1);
    `CHK(board_test_mode, 1'b0)
    summarize();
  end
endmodule
